/* rtl/lom_pkg.sv */
package lom_pkg;

	// ----------------------------------------------------------------
	// Register map (word offsets on the plain port)
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_CTRL      = 6'h00;
	localparam logic [5:0] REG_SCALE_LO  = 6'h01;
	localparam logic [5:0] REG_SCALE_HI  = 6'h02;
	localparam logic [5:0] REG_TEMP      = 6'h03;
	localparam logic [5:0] REG_STATUS    = 6'h04;
	localparam logic [5:0] REG_SETPOINT  = 6'h05;
	localparam logic [5:0] REG_ALM_CFG   = 6'h06;
	localparam logic [5:0] REG_ALM_HI    = 6'h07;
	localparam logic [5:0] REG_ALM_LO    = 6'h08;
	localparam logic [5:0] REG_ALM_TRIG  = 6'h09;
	localparam logic [5:0] REG_ALM_RECV  = 6'h0A;
	localparam logic [5:0] REG_TX_NORM   = 6'h0B;
	localparam logic [5:0] REG_TX_ALT    = 6'h0C;
	localparam logic [5:0] REG_PW_SET    = 6'h0D;
	localparam logic [5:0] REG_PW_LOGIN  = 6'h0E;
	localparam logic [5:0] REG_PW_CMD    = 6'h0F;
	localparam logic [5:0] REG_DATA      = 6'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_LOOP_MODE = 0;
	localparam int CTRL_OVER_HIGH = 1;
	localparam int CTRL_UNDR_HIGH = 2;
	localparam int CTRL_FACTORY   = 3;
	localparam int CTRL_DIG_MODEL = 4;
	localparam int ACFG_EN        = 0;
	localparam int ACFG_BELOW     = 1;
	localparam int ACFG_NOTIFY    = 2;
	localparam int ACFG_OUT_EN    = 3;
	localparam int ACFG_ALT_TX    = 4;
	localparam int ACFG_RECOVER   = 5;
	localparam int ACFG_RESTORE   = 6;
	localparam int PWC_CLEAR      = 0;
	localparam int PWC_RESET      = 1;

	// ----------------------------------------------------------------
	// Values: temperatures in 0.01 degC, currents in 1 uA
	// ----------------------------------------------------------------
	localparam logic signed [31:0] SCALE_LO_RST = 32'sh0000_0000;
	localparam logic signed [31:0] SCALE_HI_RST = 32'sh0000_2710;
	localparam logic [15:0] CUR_MIN_UA     = 16'h0FA0;
	localparam logic [15:0] CUR_MAX_UA     = 16'h4E20;
	localparam logic [15:0] CUR_FLT_HI_UA  = 16'h53FC;
	localparam logic [15:0] CUR_FLT_LO_UA  = 16'h0ED8;
	localparam logic [31:0] TX_NORM_RST    = 32'h0000_00C8;
	localparam logic [1:0]  LOGIN_MAX_FAIL = 2'h3;
	localparam logic [4:0]  CTRL_RST       = 5'h03;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [31:0] wdata;
	} lom_bus_s;

	typedef struct packed {
		logic over;
		logic under;
		logic loop_err;
	} lom_flt_s;

endpackage

/* rtl/lom_scale.sv */
`timescale 1ns/1ps
`default_nettype none
module lom_scale
	import lom_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	input  wire logic signed [31:0] temp,
	input  wire logic signed [31:0] lo,
	input  wire logic signed [31:0] hi,
	output logic             [15:0] ua_ff
);
	wire logic signed [33:0] num_w  = 34'(temp) - 34'(lo);
	wire logic signed [33:0] span_w = 34'(hi) - 34'(lo);
	wire logic signed [49:0] prod_w = 50'(num_w) * 50'sd16000;
	wire logic signed [49:0] quo_w  = (span_w > 0) ? prod_w / 50'(span_w) : 50'sd0;
	wire logic [15:0] nxt_ua = (temp <= lo) ? CUR_MIN_UA :
	                           (temp >= hi) ? CUR_MAX_UA :
	                           CUR_MIN_UA + quo_w[15:0];

	// Linear map of the span onto minimum..maximum current
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ua_ff <= CUR_MIN_UA;
		else if (ce)
			ua_ff <= nxt_ua;
	end
endmodule
`default_nettype wire

/* rtl/lom_dur.sv */
`timescale 1ns/1ps
`default_nettype none
module lom_dur (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        en,
	input  wire logic        cond,
	input  wire logic        recov_en,
	input  wire logic [31:0] trig_cyc,
	input  wire logic [31:0] recv_cyc,
	output logic             alarm_ff
);
	logic [31:0] cnt_ff;
	wire logic want_w  = alarm_ff ? !cond : cond;
	wire logic [31:0] lim_w = alarm_ff ? recv_cyc : trig_cyc;
	wire logic done_w  = want_w && (cnt_ff >= lim_w);

	// Counts continuous time of the opposite state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff   <= 32'h0000_0000;
			alarm_ff <= 1'b0;
		end else if (ce) begin
			if (!en) begin
				cnt_ff   <= 32'h0000_0000;
				alarm_ff <= 1'b0;
			end else if (done_w) begin
				cnt_ff <= 32'h0000_0000;
				if (!alarm_ff || recov_en)
					alarm_ff <= !alarm_ff;
			end else if (want_w)
				cnt_ff <= cnt_ff + 32'h0000_0001;
			else
				cnt_ff <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* rtl/lom_top.sv */
// Behaviour
// - Loop-powered mode disables discrete input channels and digital outputs.
// - Measured temperature drives the loop current setpoint by default.
// - Low and high endpoints set the span mapped onto loop current.
// - Temperature at low endpoint gives minimum current.
// - Temperature at high endpoint gives maximum current.
// - Factory restore loads endpoints with 0 and 100 degrees.
// - Above high endpoint: flag over-range, drive selectable fault current.
// - Over-range selects high fault current by default.
// - Below low endpoint: flag under-range, fault current defaults low.
// - Low loop voltage raises loop error and forces low error current.
// - Alarm compares input above high or below low threshold.
// - Alarm asserts only after condition holds for trigger duration.
// - On alarm: optional notify, optional output drive, optional alternate interval.
// - Alarm output drive only on digital-output models.
// - Optional recovery clears alarm after absence duration; optional restore returns normal interval.
// - Transmit interval sets spacing between successive readings.
// - With password set, stored data is withheld until login.
// - Clear-password removes protection.
// - Password reset deletes password and erases logged data.
// - Three failed logins lock login until power cycle.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lom_top
	import lom_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	input  wire logic [5:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	input  wire logic signed [31:0] temp_in,
	input  wire logic               loop_low,
	input  wire logic [3:0]         discrete_io_channels,
	output logic [31:0]             rdata_ff,
	output logic [15:0]             ua_set_ff,
	output logic                    over_ff,
	output logic                    under_ff,
	output logic                    loop_err_ff,
	output logic                    alarm_ff,
	output logic                    notify_ff,
	output logic                    alm_out_ff,
	output logic                    dig_out_ff,
	output logic [3:0]              discrete_io_channels_ff,
	output logic                    sample_ff,
	output logic                    log_erase_ff
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	lom_bus_s          bus_w;
	lom_flt_s          flt_w;
	logic [4:0]        ctrl_ff;
	logic signed [31:0] lo_ff;
	logic signed [31:0] hi_ff;
	logic [6:0]        acfg_ff;
	logic signed [31:0] ahi_ff;
	logic signed [31:0] alo_ff;
	logic [31:0]       atrig_ff;
	logic [31:0]       arecv_ff;
	logic [31:0]       txn_ff;
	logic [31:0]       txa_ff;
	logic [31:0]       pw_ff;
	logic              pw_set_ff;
	logic              auth_ff;
	logic [1:0]        fail_ff;
	logic [31:0]       data_ff;
	logic [31:0]       tx_cnt_ff;
	logic              alm_d_ff;
	logic              alt_ff;
	logic [15:0]       map_ua;
	logic              alm_raw;

	assign bus_w = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic wr_ctrl   = bus_w.wr && bus_w.addr == REG_CTRL;
	wire logic wr_lo     = bus_w.wr && bus_w.addr == REG_SCALE_LO;
	wire logic wr_hi     = bus_w.wr && bus_w.addr == REG_SCALE_HI;
	wire logic wr_acfg   = bus_w.wr && bus_w.addr == REG_ALM_CFG;
	wire logic wr_ahi    = bus_w.wr && bus_w.addr == REG_ALM_HI;
	wire logic wr_alo    = bus_w.wr && bus_w.addr == REG_ALM_LO;
	wire logic wr_atrig  = bus_w.wr && bus_w.addr == REG_ALM_TRIG;
	wire logic wr_arecv  = bus_w.wr && bus_w.addr == REG_ALM_RECV;
	wire logic wr_txn    = bus_w.wr && bus_w.addr == REG_TX_NORM;
	wire logic wr_txa    = bus_w.wr && bus_w.addr == REG_TX_ALT;
	wire logic wr_pwset  = bus_w.wr && bus_w.addr == REG_PW_SET;
	wire logic wr_login  = bus_w.wr && bus_w.addr == REG_PW_LOGIN;
	wire logic wr_pwcmd  = bus_w.wr && bus_w.addr == REG_PW_CMD;
	wire logic wr_data   = bus_w.wr && bus_w.addr == REG_DATA;

	wire logic factory_w = wr_ctrl && bus_w.wdata[CTRL_FACTORY];
	wire logic locked_w  = (fail_ff == LOGIN_MAX_FAIL);
	wire logic login_ok  = wr_login && !locked_w && (bus_w.wdata == pw_ff);
	wire logic login_bad = wr_login && !locked_w && (bus_w.wdata != pw_ff);
	wire logic pw_clr_w  = wr_pwcmd && bus_w.wdata[PWC_CLEAR];
	wire logic pw_rst_w  = wr_pwcmd && bus_w.wdata[PWC_RESET];
	wire logic access_w  = !pw_set_ff || auth_ff;

	// ----------------------------------------------------------------
	// Mapping and faults
	// ----------------------------------------------------------------
	lom_scale u_scale (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.temp  (temp_in),
		.lo    (lo_ff),
		.hi    (hi_ff),
		.ua_ff (map_ua)
	);

	assign flt_w = '{over:     temp_in > hi_ff,
	                 under:    temp_in < lo_ff,
	                 loop_err: loop_low};

	wire logic [15:0] over_ua  = ctrl_ff[CTRL_OVER_HIGH] ? CUR_FLT_HI_UA : CUR_FLT_LO_UA;
	wire logic [15:0] undr_ua  = ctrl_ff[CTRL_UNDR_HIGH] ? CUR_FLT_HI_UA : CUR_FLT_LO_UA;
	wire logic [15:0] nxt_ua_set = loop_err_ff ? CUR_FLT_LO_UA :
	                               over_ff     ? over_ua :
	                               under_ff    ? undr_ua : map_ua;

	// ----------------------------------------------------------------
	// Alarm
	// ----------------------------------------------------------------
	wire logic acond_w = acfg_ff[ACFG_BELOW] ? (temp_in < alo_ff) : (temp_in > ahi_ff);

	lom_dur u_dur (
		.clk      (clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.en       (acfg_ff[ACFG_EN]),
		.cond     (acond_w),
		.recov_en (acfg_ff[ACFG_RECOVER]),
		.trig_cyc (atrig_ff),
		.recv_cyc (arecv_ff),
		.alarm_ff (alm_raw)
	);

	wire logic loop_mode_w = ctrl_ff[CTRL_LOOP_MODE];
	wire logic out_ok_w    = ctrl_ff[CTRL_DIG_MODEL] && !loop_mode_w;
	wire logic [31:0] tx_lim_w = alt_ff ? txa_ff : txn_ff;
	// Hit on the last count so readings stand exactly one interval apart
	wire logic tx_hit_w    = (tx_cnt_ff + 32'h0000_0001) >= tx_lim_w;

	wire logic [31:0] rd_mux =
		(bus_w.addr == REG_CTRL)     ? {27'h000_0000, ctrl_ff} :
		(bus_w.addr == REG_SCALE_LO) ? lo_ff :
		(bus_w.addr == REG_SCALE_HI) ? hi_ff :
		(bus_w.addr == REG_TEMP)     ? temp_in :
		(bus_w.addr == REG_STATUS)   ? {24'h00_0000, locked_w, auth_ff, pw_set_ff,
		                                alm_raw, loop_err_ff, under_ff, over_ff, 1'b0} :
		(bus_w.addr == REG_SETPOINT) ? {16'h0000, ua_set_ff} :
		(bus_w.addr == REG_ALM_CFG)  ? {25'h000_0000, acfg_ff} :
		(bus_w.addr == REG_ALM_HI)   ? ahi_ff :
		(bus_w.addr == REG_ALM_LO)   ? alo_ff :
		(bus_w.addr == REG_ALM_TRIG) ? atrig_ff :
		(bus_w.addr == REG_ALM_RECV) ? arecv_ff :
		(bus_w.addr == REG_TX_NORM)  ? txn_ff :
		(bus_w.addr == REG_TX_ALT)   ? txa_ff :
		(bus_w.addr == REG_DATA)     ? (access_w ? data_ff : 32'h0000_0000) :
		32'h0000_0000;

	// ----------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff  <= CTRL_RST;
			lo_ff    <= SCALE_LO_RST;
			hi_ff    <= SCALE_HI_RST;
			acfg_ff  <= 7'h00;
			ahi_ff   <= 32'sh0000_0000;
			alo_ff   <= 32'sh0000_0000;
			atrig_ff <= 32'h0000_0000;
			arecv_ff <= 32'h0000_0000;
			txn_ff   <= TX_NORM_RST;
			txa_ff   <= TX_NORM_RST;
		end else if (ce) begin
			if (factory_w) begin
				ctrl_ff <= CTRL_RST;
				lo_ff   <= SCALE_LO_RST;
				hi_ff   <= SCALE_HI_RST;
			end else if (access_w) begin
				if (wr_ctrl)
					ctrl_ff <= bus_w.wdata[4:0];
				if (wr_lo)
					lo_ff <= bus_w.wdata;
				if (wr_hi)
					hi_ff <= bus_w.wdata;
			end
			if (access_w) begin
				if (wr_acfg)
					acfg_ff <= bus_w.wdata[6:0];
				if (wr_ahi)
					ahi_ff <= bus_w.wdata;
				if (wr_alo)
					alo_ff <= bus_w.wdata;
				if (wr_atrig)
					atrig_ff <= bus_w.wdata;
				if (wr_arecv)
					arecv_ff <= bus_w.wdata;
				if (wr_txn)
					txn_ff <= bus_w.wdata;
				if (wr_txa)
					txa_ff <= bus_w.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Password
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pw_ff     <= 32'h0000_0000;
			pw_set_ff <= 1'b0;
			auth_ff   <= 1'b0;
			fail_ff   <= 2'h0;
		end else if (ce) begin
			if (pw_rst_w || pw_clr_w) begin
				pw_set_ff <= 1'b0;
				pw_ff     <= 32'h0000_0000;
				auth_ff   <= 1'b0;
			end else if (wr_pwset && access_w) begin
				pw_set_ff <= 1'b1;
				pw_ff     <= bus_w.wdata;
			end
			if (login_ok) begin
				auth_ff <= 1'b1;
				fail_ff <= 2'h0;
			end else if (login_bad) begin
				auth_ff <= 1'b0;
				fail_ff <= fail_ff + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Data, outputs, transmit pacing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_ff      <= 32'h0000_0000;
			log_erase_ff <= 1'b0;
			rdata_ff     <= 32'h0000_0000;
			ua_set_ff    <= CUR_MIN_UA;
			over_ff      <= 1'b0;
			under_ff     <= 1'b0;
			loop_err_ff  <= 1'b0;
			alarm_ff     <= 1'b0;
			alm_d_ff     <= 1'b0;
			alt_ff       <= 1'b0;
			notify_ff    <= 1'b0;
			alm_out_ff   <= 1'b0;
			dig_out_ff   <= 1'b0;
			discrete_io_channels_ff <= 4'h0;
			tx_cnt_ff    <= 32'h0000_0000;
			sample_ff    <= 1'b0;
		end else if (ce) begin
			log_erase_ff <= pw_rst_w;
			if (pw_rst_w)
				data_ff <= 32'h0000_0000;
			else if (sample_ff)
				data_ff <= temp_in;
			else if (wr_data && access_w)
				data_ff <= bus_w.wdata;
			rdata_ff    <= bus_w.rd ? rd_mux : 32'h0000_0000;
			over_ff     <= flt_w.over;
			under_ff    <= flt_w.under;
			loop_err_ff <= flt_w.loop_err;
			ua_set_ff   <= nxt_ua_set;
			alm_d_ff    <= alm_raw;
			alarm_ff    <= alm_raw;
			if (alm_raw && !alm_d_ff)
				alt_ff <= acfg_ff[ACFG_ALT_TX];
			else if (!alm_raw && alm_d_ff && acfg_ff[ACFG_RESTORE])
				alt_ff <= 1'b0;
			notify_ff   <= alm_raw && !alm_d_ff && acfg_ff[ACFG_NOTIFY];
			alm_out_ff  <= alm_raw && acfg_ff[ACFG_OUT_EN] && out_ok_w;
			dig_out_ff  <= out_ok_w && alm_raw && acfg_ff[ACFG_OUT_EN];
			discrete_io_channels_ff <= loop_mode_w ? 4'h0 : discrete_io_channels;
			sample_ff   <= tx_hit_w;
			tx_cnt_ff   <= tx_hit_w ? 32'h0000_0000 : tx_cnt_ff + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_loop_err;
		@(posedge clk) disable iff (!rst_b)
		ce && loop_err_ff |=> ua_set_ff == CUR_FLT_LO_UA;
	endproperty
	a_loop_err: assert property (p_loop_err) else $error("loop error current wrong");

	property p_over;
		@(posedge clk) disable iff (!rst_b)
		ce && over_ff && !loop_err_ff && ctrl_ff[CTRL_OVER_HIGH] |=> ua_set_ff == CUR_FLT_HI_UA;
	endproperty
	a_over: assert property (p_over) else $error("over-range current wrong");

	property p_under;
		@(posedge clk) disable iff (!rst_b)
		ce && under_ff && !over_ff && !loop_err_ff && !ctrl_ff[CTRL_UNDR_HIGH]
		|=> ua_set_ff == CUR_FLT_LO_UA;
	endproperty
	a_under: assert property (p_under) else $error("under-range current wrong");

	property p_discrete_off;
		@(posedge clk) disable iff (!rst_b)
		ce && loop_mode_w |=> discrete_io_channels_ff == 4'h0 && !dig_out_ff;
	endproperty
	a_discrete_off: assert property (p_discrete_off) else $error("discrete io active in loop mode");

	property p_factory;
		@(posedge clk) disable iff (!rst_b)
		ce && factory_w |=> lo_ff == SCALE_LO_RST && hi_ff == SCALE_HI_RST;
	endproperty
	a_factory: assert property (p_factory) else $error("factory restore failed");

	property p_lock;
		@(posedge clk) disable iff (!rst_b)
		ce && locked_w |=> !$rose(auth_ff) && locked_w;
	endproperty
	a_lock: assert property (p_lock) else $error("login after lockout");

	property p_login_clr;
		@(posedge clk) disable iff (!rst_b)
		ce && login_ok |=> fail_ff == 2'h0 && auth_ff;
	endproperty
	a_login_clr: assert property (p_login_clr) else $error("fail count not cleared");

	property p_protect;
		@(posedge clk) disable iff (!rst_b)
		ce && bus_w.rd && bus_w.addr == REG_DATA && pw_set_ff && !auth_ff |=> rdata_ff == 32'h0;
	endproperty
	a_protect: assert property (p_protect) else $error("data released while protected");

	property p_reset_pw;
		@(posedge clk) disable iff (!rst_b)
		ce && pw_rst_w |=> !pw_set_ff && data_ff == 32'h0 && log_erase_ff;
	endproperty
	a_reset_pw: assert property (p_reset_pw) else $error("password reset incomplete");

	property p_model;
		@(posedge clk) disable iff (!rst_b)
		ce && !ctrl_ff[CTRL_DIG_MODEL] |=> !alm_out_ff;
	endproperty
	a_model: assert property (p_model) else $error("alarm output on analog model");
endmodule
`default_nettype wire

/* tb/lom_loop_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module lom_loop_rx
	import lom_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] ua,
	input  wire logic        starve,
	output logic             loop_low,
	output logic             flt_lo,
	output logic             flt_hi
);
	// ----------------------------------------------------------------
	// Loop supply and current classification
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_low <= 1'b0;
			flt_lo   <= 1'b0;
			flt_hi   <= 1'b0;
		end else begin
			loop_low <= starve;
			flt_lo   <= (ua < CUR_MIN_UA);
			flt_hi   <= (ua > CUR_MAX_UA);
		end
	end
endmodule
`default_nettype wire

/* tb/lom_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lom_top_tb_top
	import lom_pkg::*;
;
	logic               clk, rst_b, ce, wr, rd, starve, loop_low, flt_lo, flt_hi;
	logic [5:0]         addr;
	logic [31:0]        wdata, rdata_ff;
	logic signed [31:0] temp_in;
	logic [3:0]         discrete_io_channels, discrete_io_channels_ff;
	logic [15:0]        ua_set_ff;
	logic over_ff, under_ff, loop_err_ff, alarm_ff, notify_ff, alm_out_ff;
	logic dig_out_ff, sample_ff, log_erase_ff, seen;
	int   fail_count, n_tests, cyc, n, i;
	int   tt[4] = '{0, 5000, 10000, 2500};
	int   tu[4] = '{4000, 12000, 20000, 8000};

	lom_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .temp_in(temp_in), .loop_low(loop_low),
		.discrete_io_channels(discrete_io_channels),
		.rdata_ff(rdata_ff), .ua_set_ff(ua_set_ff), .over_ff(over_ff),
		.under_ff(under_ff), .loop_err_ff(loop_err_ff), .alarm_ff(alarm_ff),
		.notify_ff(notify_ff), .alm_out_ff(alm_out_ff), .dig_out_ff(dig_out_ff),
		.discrete_io_channels_ff(discrete_io_channels_ff),
		.sample_ff(sample_ff), .log_erase_ff(log_erase_ff));
	lom_loop_rx rx (.clk(clk), .rst_b(rst_b), .ua(ua_set_ff), .starve(starve),
		.loop_low(loop_low), .flt_lo(flt_lo), .flt_hi(flt_hi));

	// ----------------------------------------------------------------
	// Clock, timeout, shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_reg(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_word(rdata_ff & m, e);
	endtask
	task automatic set_temp(input int t);
		@(posedge clk);
		temp_in <= t;
		step(5);
	endtask
	task automatic reset_dut();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic wait_alarm(input logic lvl);
		n    = 0;
		seen = 1'b0;
		while (alarm_ff !== lvl && n < 40) begin
			step(1);
			n++;
			seen |= notify_ff;
		end
		step(1);
		seen |= notify_ff;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk_word(ua_set_ff, 32'h0000_0FA0);
		chk_word(discrete_io_channels_ff, 32'h0000_0000);
		chk_reg(REG_CTRL, 32'h0000_0017, 32'h0000_0003);
		chk_reg(REG_SCALE_HI, 32'hFFFF_FFFF, 32'h0000_2710);
		chk_reg(REG_TX_NORM, 32'hFFFF_FFFF, 32'h0000_00C8);
		chk_reg(REG_STATUS, 32'h0000_00E0, 32'h0000_0000);
		chk_reg(6'h3F, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	task automatic t_map();
		for (i = 0; i < 4; i++) begin
			set_temp(tt[i]);
			chk_word(ua_set_ff, tu[i]);
		end
		wr_reg(REG_SCALE_LO, 32'h0000_03E8);
		set_temp(1000);
		chk_word(ua_set_ff, 32'h0000_0FA0);
		wr_reg(REG_SCALE_HI, 32'h0000_07D0);
		wr_reg(REG_CTRL, 32'h0000_000B);
		step(4);
		chk_reg(REG_SCALE_LO, 32'hFFFF_FFFF, 32'h0000_0000);
		chk_reg(REG_SCALE_HI, 32'hFFFF_FFFF, 32'h0000_2710);
	endtask
	task automatic t_fault();
		set_temp(10001);
		chk_word({over_ff, flt_hi, ua_set_ff}, 32'h0003_53FC);
		chk_reg(REG_STATUS, 32'h0000_0002, 32'h0000_0002);
		wr_reg(REG_CTRL, 32'h0000_0001);
		step(4);
		chk_word(ua_set_ff, 32'h0000_0ED8);
		set_temp(-1);
		chk_word({under_ff, flt_lo, ua_set_ff}, 32'h0003_0ED8);
		wr_reg(REG_CTRL, 32'h0000_0005);
		step(4);
		chk_word(ua_set_ff, 32'h0000_53FC);
		starve <= 1'b1;
		step(5);
		chk_word({loop_err_ff, ua_set_ff}, 32'h0001_0ED8);
		starve <= 1'b0;
		wr_reg(REG_CTRL, 32'h0000_0003);
		set_temp(1000);
	endtask
	task automatic t_alarm();
		wr_reg(REG_ALM_HI, 32'h0000_1388);
		wr_reg(REG_ALM_TRIG, 32'h0000_0006);
		wr_reg(REG_ALM_RECV, 32'h0000_0008);
		wr_reg(REG_ALM_CFG, 32'h0000_002D);
		@(posedge clk);
		temp_in <= 6000;
		repeat (3) @(posedge clk);
		temp_in <= 1000;
		step(12);
		chk_word(alarm_ff, 32'h0000_0000);
		@(posedge clk);
		temp_in <= 6000;
		wait_alarm(1'b1);
		chk_word(n == 7 || n == 8, 32'h0000_0001);
		chk_word({seen, alm_out_ff}, 32'h0000_0002);
		wr_reg(REG_CTRL, 32'h0000_0012);
		step(4);
		chk_word({alm_out_ff, discrete_io_channels_ff}, 32'h0000_001F);
		chk_word(dig_out_ff, 32'h0000_0001);
		@(posedge clk);
		temp_in <= 1000;
		wait_alarm(1'b0);
		chk_word(n == 9 || n == 10, 32'h0000_0001);
		wr_reg(REG_CTRL, 32'h0000_0003);
	endtask
	task automatic tx_gap();
		step(1);
		n = 0;
		while (sample_ff !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		n = 0;
		step(1);
		while (sample_ff !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		n++;
	endtask
	task automatic t_tx();
		wr_reg(REG_TX_NORM, 32'h0000_0014);
		tx_gap();
		chk_word(n, 32'h0000_0014);
	endtask
	task automatic t_alt();
		wr_reg(REG_ALM_LO, 32'h0000_01F4);
		wr_reg(REG_TX_ALT, 32'h0000_000A);
		wr_reg(REG_ALM_CFG, 32'h0000_0033);
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			temp_in <= 0;
			wait_alarm(1'b1);
			chk_word(n, 32'h0000_0008);
			tx_gap();
			chk_word(n, 32'h0000_000A);
			@(posedge clk);
			temp_in <= 1000;
			wait_alarm(1'b0);
			tx_gap();
			chk_word(n, i ? 32'h0000_0014 : 32'h0000_000A);
			wr_reg(REG_ALM_CFG, 32'h0000_0073);
		end
	endtask
	task automatic t_pw();
		wr_reg(REG_PW_SET, 32'h0000_1234);
		chk_reg(REG_STATUS, 32'h0000_0020, 32'h0000_0020);
		chk_reg(REG_DATA, 32'hFFFF_FFFF, 32'h0000_0000);
		wr_reg(REG_PW_LOGIN, 32'h0000_0001);
		wr_reg(REG_PW_LOGIN, 32'h0000_0001);
		wr_reg(REG_PW_LOGIN, 32'h0000_1234);
		chk_reg(REG_STATUS, 32'h0000_00C0, 32'h0000_0040);
		chk_reg(REG_DATA, 32'hFFFF_FFFF, 32'h0000_03E8);
		wr_reg(REG_PW_LOGIN, 32'h0000_0001);
		wr_reg(REG_PW_LOGIN, 32'h0000_0001);
		chk_reg(REG_STATUS, 32'h0000_0080, 32'h0000_0000);
		wr_reg(REG_PW_LOGIN, 32'h0000_0001);
		wr_reg(REG_PW_LOGIN, 32'h0000_1234);
		chk_reg(REG_STATUS, 32'h0000_0080, 32'h0000_0080);
		wr_reg(REG_PW_CMD, 32'h0000_0002);
		#1;
		seen = log_erase_ff;
		repeat (3) begin
			step(1);
			seen |= log_erase_ff;
		end
		chk_word(seen, 32'h0000_0001);
		chk_reg(REG_STATUS, 32'h0000_0020, 32'h0000_0000);
		reset_dut();
		chk_reg(REG_STATUS, 32'h0000_0080, 32'h0000_0000);
		wr_reg(REG_PW_SET, 32'h0000_0055);
		wr_reg(REG_PW_CMD, 32'h0000_0001);
		chk_reg(REG_STATUS, 32'h0000_0020, 32'h0000_0000);
	endtask

	initial begin
		rst_b   = 1'b0;
		ce      = 1'b1;
		wr      = 1'b0;
		rd      = 1'b0;
		addr    = 6'h00;
		wdata   = 32'h0000_0000;
		temp_in = 0;
		discrete_io_channels = 4'hF;
		starve  = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_map();
		t_fault();
		t_alarm();
		t_tx();
		t_alt();
		t_pw();
		wrap_up();
	end
endmodule
`default_nettype wire
